// File: adcc_ctrl.sv
// converter digital control: conversion sequencing, configuration port, pin drivers
`timescale 1ns/100ps
module adcc_ctrl
  import adcc_pkg::*;
(
  input  wire logic              i_sys_clk,                 // system clock
  input  wire logic              i_arst_n,                  // async reset, low active
  input  wire logic              i_reset_pin,               // reset pin, high active
  input  wire logic              i_convert_start_n,         // conversion start, falling edge
  input  wire logic              i_power_down_in,           // power down request
  input  wire logic              i_serial_parallel_sel,     // 1 serial, 0 parallel
  input  wire logic              i_pin_or_register_cfg,     // 1 pins, 0 register
  input  wire logic              i_clock_source_sel,        // 1 external, 0 internal
  input  wire logic              i_read_during_convert_sel, // read timing select
  input  wire logic              i_wide_range_select,       // wide range pin
  input  wire logic              i_bipolar_sel,             // signed range pin
  input  wire logic              i_rd_n,                    // read strobe, low active
  input  wire logic              i_cs_n,                    // chip select, low active
  input  wire logic              i_cfg_clock_polarity,      // shift edge select
  input  wire logic              i_cfg_serial_in,           // configuration data
  input  wire logic [RES_W-1:0]  i_sar_result,              // result from the core
  input  wire logic              i_pin14,                   // shared pin a, level in
  output logic                   o_pin14,                   // shared pin a, driven level
  output logic                   o_pin14_oe_n,              // shared pin a, low drives
  input  wire logic              i_pin15,                   // shared pin b, level in
  output logic                   o_pin15,                   // shared pin b, driven level
  output logic                   o_pin15_oe_n,              // shared pin b, low drives
  output logic [13:0]            o_data_lo,                 // parallel bits 13..0
  output logic                   o_data_oe_n,               // parallel drivers, low drives
  output logic                   o_serial_out_en,           // serial output driver enable
  output logic                   o_ext_clk_gate,            // pass external serial clock
  output logic                   o_busy,                    // conversion busy
  output logic                   o_sample_hold,             // sampler in hold
  output logic [1:0]             o_range,                   // {signed, wide}
  output logic [CFG_W-1:0]       o_cfg_reg,                 // configuration register
  output logic                   o_power_down               // analog power down
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [SYNC_W-1:0] pins_raw; // raw pin vector
  logic [SYNC_W-1:0] pins_s;   // synchronised pin vector

  assign pins_raw = {i_cfg_serial_in, i_pin15, i_pin14, i_cfg_clock_polarity,
                     i_cs_n, i_rd_n, i_bipolar_sel, i_wide_range_select,
                     i_read_during_convert_sel, i_clock_source_sel,
                     i_pin_or_register_cfg, i_serial_parallel_sel, i_reset_pin,
                     i_power_down_in, i_convert_start_n};

  adcc_sync #(.W(SYNC_W), .RST_VAL(SYNC_IDLE)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (pins_raw),
    .o_sync    (pins_s)
  );

  // shared pins are only meaningful as inputs in serial mode
  logic rst_s;  // reset pin level
  logic ser_s;  // serial mode
  logic sw_cfg; // register configuration active
  assign rst_s  = pins_s[S_RST];
  assign ser_s  = pins_s[S_SER];
  assign sw_cfg = ser_s & ~pins_s[S_HW];

  // ************************************************************
  // edge history
  // ************************************************************
  logic prev_cnv, next_prev_cnv; // convert start history
  logic prev_rst, next_prev_rst; // reset pin history
  logic prev_sck, next_prev_sck; // shift clock history
  logic cnv_fall;                // convert start falling
  logic rst_fall;                // reset pin falling
  logic sck_active;              // selected shift edge seen

  // history starts high on the low-active start so reset release is no edge
  always_comb begin
    next_prev_cnv = pins_s[S_CNV];
    next_prev_rst = rst_s;
    next_prev_sck = pins_s[S_SCK];
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_cnv <= 1'b1;
      prev_rst <= 1'b0;
      prev_sck <= 1'b0;
    end else begin
      prev_cnv <= next_prev_cnv;
      prev_rst <= next_prev_rst;
      prev_sck <= next_prev_sck;
    end
  end

  assign cnv_fall = prev_cnv & ~pins_s[S_CNV];
  assign rst_fall = prev_rst & ~rst_s;
  // polarity low samples on the rising edge, high on the falling edge
  assign sck_active = pins_s[S_POL] ? (prev_sck & ~pins_s[S_SCK])
                                    : (~prev_sck & pins_s[S_SCK]);

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  adcc_state_t      state, next_state;   // sequencer state
  logic [15:0]      cnt, next_cnt;       // cycles left in the phase
  logic [RES_W-1:0] result, next_result; // loaded output word
  logic             start_ok;            // accepted conversion start
  logic             ext_mode;            // lengthened busy mode
  logic             load;                // result enters output register

  // a start during power down or during a conversion is dropped quietly
  assign start_ok = cnv_fall & ~pins_s[S_PD] & ~rst_s & (state == ST_IDLE);
  // lengthened busy only in serial master read-after-convert mode
  assign ext_mode = ser_s & ~pins_s[S_EXT] & ~pins_s[S_RDC];

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    load        = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_CONVERT;
          next_cnt   = CONV_CYC - 16'h0001;
        end
      end
      ST_CONVERT: begin
        if (cnt == 16'h0000) begin
          if (ext_mode) begin
            next_state = ST_EXTEND;
            next_cnt   = EXT_CYC - 16'h0001;
          end else begin
            next_state = ST_IDLE;
            load       = 1'b1;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      ST_EXTEND: begin
        if (cnt == 16'h0000) begin
          next_state = ST_IDLE;
          load       = 1'b1;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = 16'h0000;
      end
    endcase
    // reset pin abandons the conversion; no result is loaded
    if (rst_s) begin
      next_state = ST_IDLE;
      next_cnt   = 16'h0000;
      load       = 1'b0;
    end
    // the output word changes only on a load or a reset clear
    next_result = result;
    if (rst_s || rst_fall) begin
      next_result = '0;
    end else if (load) begin
      next_result = i_sar_result;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state  <= ST_IDLE;
      cnt    <= 16'h0000;
      result <= '0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      result <= next_result;
    end
  end

  // ************************************************************
  // serial configuration register
  // ************************************************************
  logic [CFG_W-1:0] cfg, next_cfg; // configuration contents
  logic             shift_en;      // one bit shifts in

  // select is low active; without it stray clock edges change nothing
  assign shift_en = sw_cfg & ~pins_s[S_SEL] & sck_active & ~rst_s & ~rst_fall;

  // reset clear beats a shift that lands in the same cycle
  always_comb begin
    next_cfg = cfg;
    if (rst_s || rst_fall) begin
      next_cfg = CFG_RESET;
    end else if (shift_en) begin
      next_cfg = {cfg[CFG_W-2:0], pins_s[S_SIN]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // drivers follow the synchronised strobes, two cycles behind the pins
  logic drive_en; // read and select both low
  assign drive_en = ~pins_s[S_RD] & ~pins_s[S_CS];

  // shared pins are inputs in serial mode, so they drive only in parallel mode
  // busy spans both phases; the sampler holds only in the first one
  assign o_pin14         = result[BIT14];
  assign o_pin15         = result[BIT15];
  assign o_pin14_oe_n    = ~(~ser_s & drive_en);
  assign o_pin15_oe_n    = ~(~ser_s & drive_en);
  assign o_data_lo       = result[13:0];
  assign o_data_oe_n     = ~(~ser_s & drive_en);
  assign o_serial_out_en = ser_s & drive_en;
  assign o_ext_clk_gate  = ser_s & pins_s[S_EXT] & ~pins_s[S_CS];
  assign o_busy          = (state != ST_IDLE);
  assign o_sample_hold   = (state == ST_CONVERT);
  assign o_range         = sw_cfg ? {cfg[CFG_BIP_BIT], cfg[CFG_TEN_BIT]}
                                  : {pins_s[S_BIP], pins_s[S_TEN]};
  assign o_cfg_reg       = cfg;
  assign o_power_down    = pins_s[S_PD];

  // ************************************************************
  // assertion helpers
  // ************************************************************
  logic [15:0] hold_len, next_hold_len; // cycles spent in the conversion phase

  // counts the hold phase so that its length can be checked as it ends
  always_comb begin
    next_hold_len = 16'h0000;
    if (state == ST_CONVERT) begin
      next_hold_len = hold_len + 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_len <= 16'h0000;
    end else begin
      hold_len <= next_hold_len;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  // end of a conversion phase that must run into the extension
  sequence s_conv_done_ext;
    (state == ST_CONVERT) && (cnt == 16'h0000) && ext_mode && !rst_s;
  endsequence

  // extension phase, still showing busy
  sequence s_extend_run;
    (state == ST_EXTEND) && o_busy;
  endsequence

  a_pin_bit14: assert property (!o_pin14_oe_n |-> o_pin14 == result[BIT14] && !ser_s)
    else $error("shared pin a not carrying bit 14");
  a_pin_bit15: assert property (!o_pin15_oe_n |-> o_pin15 == result[BIT15] && !ser_s)
    else $error("shared pin b not carrying bit 15");
  a_shared_pins_free: assert property (ser_s |-> o_pin14_oe_n && o_pin15_oe_n && o_data_oe_n)
    else $error("parallel drivers on in serial mode");
  a_cfg_shift_in: assert property (shift_en |=> cfg == {$past(cfg[CFG_W-2:0]), $past(pins_s[S_SIN])})
    else $error("configuration bit not shifted in msb first");
  a_cfg_edge_pol: assert property ($changed(cfg) && !$past(rst_s) && !$past(rst_fall) |-> $past(sck_active) && $past(sw_cfg))
    else $error("configuration changed without active shift edge");
  a_cfg_sel_gate: assert property (pins_s[S_SEL] && !rst_s && !rst_fall |=> $stable(cfg))
    else $error("configuration moved with port select inactive");
  a_busy_start: assert property (start_ok |=> o_busy && o_sample_hold)
    else $error("busy did not rise on start");
  a_result_load: assert property ($fell(o_busy) && !$past(rst_s) |-> result == $past(i_sar_result))
    else $error("result not loaded as busy fell");
  a_hold_length: assert property ($fell(o_sample_hold) && !$past(rst_s) |-> hold_len == CONV_CYC)
    else $error("conversion phase length wrong");
  a_extend_busy: assert property (s_conv_done_ext |=> s_extend_run)
    else $error("busy not extended in read-after-convert master mode");
  a_range_pins: assert property (!sw_cfg |-> o_range == {pins_s[S_BIP], pins_s[S_TEN]})
    else $error("range not taken from pins");
  a_drive_gate: assert property (!o_data_oe_n || o_serial_out_en |-> !pins_s[S_RD] && !pins_s[S_CS])
    else $error("drivers on without read and select");
  a_ext_clk: assert property (o_ext_clk_gate |-> !pins_s[S_CS] && pins_s[S_EXT])
    else $error("external clock passed without chip select");
  a_reset_abort: assert property (rst_s |=> !o_busy ##1 (!o_busy || $past(start_ok)))
    else $error("conversion kept running under reset");
  a_reset_clear: assert property ($fell(rst_s) |=> result == '0 && cfg == CFG_RESET)
    else $error("reset release left data or configuration");
  a_pd_refuse: assert property (pins_s[S_PD] && !o_busy |=> !o_busy)
    else $error("conversion started in power down");

endmodule : adcc_ctrl

// File: adcc_ctrl_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcc_ctrl_bench
  import adcc_pkg::*;
;
  // ************************************************************
  // stimulus, dut and host
  // ************************************************************
  logic             clk, arst_n, rst_pin, pd, ser, hw, ext, read_during_convert_sel, wide_range_select, bip, rd_n, cs_n, pol;
  logic [RES_W-1:0] sar;                          // core result fed to the dut
  wire              cst_n, sck, sel_n, sdat;      // host drives
  logic             o14, oe14, o15, oe15, doe, soe, gate, busy, sh, pdo;
  logic [13:0]      dlo;                          // parallel low bits
  logic [1:0]       rng;                          // range out
  logic [CFG_W-1:0] cfg;                          // configuration register
  int               n_fail, comparisons;          // mismatch and compare counts
  // shared pins: the dut wins while enabled, otherwise the host level
  wire              p14 = !oe14 ? o14 : sck;
  wire              p15 = !oe15 ? o15 : sel_n;

  always #5 clk = ~clk;

  adcc_host host (.i_sys_clk(clk), .i_busy(busy), .o_convert_start_n(cst_n),
    .o_sck(sck), .o_sel_n(sel_n), .o_sdata(sdat));

  adcc_ctrl u_dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_reset_pin(rst_pin),
    .i_convert_start_n(cst_n), .i_power_down_in(pd), .i_serial_parallel_sel(ser),
    .i_pin_or_register_cfg(hw), .i_clock_source_sel(ext), .i_read_during_convert_sel(read_during_convert_sel),
    .i_wide_range_select(wide_range_select), .i_bipolar_sel(bip), .i_rd_n(rd_n), .i_cs_n(cs_n),
    .i_cfg_clock_polarity(pol), .i_cfg_serial_in(sdat), .i_sar_result(sar),
    .i_pin14(p14), .o_pin14(o14), .o_pin14_oe_n(oe14), .i_pin15(p15), .o_pin15(o15),
    .o_pin15_oe_n(oe15), .o_data_lo(dlo), .o_data_oe_n(doe), .o_serial_out_en(soe),
    .o_ext_clk_gate(gate), .o_busy(busy), .o_sample_hold(sh), .o_range(rng),
    .o_cfg_reg(cfg), .o_power_down(pdo));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one conversion; counts busy and hold cycles, bounded
  task automatic run_conv(output int hi, output int shc);
    int k;
    hi  = 0;
    shc = 0;
    fork
      host.start_conv();
      for (k = 0; k < 2000 && !(hi > 0 && busy === 1'b0); k++) begin
        @(negedge clk);
        if (busy === 1'b1) hi++;
        if (sh === 1'b1) shc++;
      end
    join
  endtask : run_conv

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog: the whole sequence needs well under 10k cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    int   hi, shc, s, k;
    logic ok;
    clk = 0; arst_n = 0; rst_pin = 0; pd = 0; ser = 0; hw = 1; ext = 0; read_during_convert_sel = 1;
    wide_range_select = 0; bip = 0; rd_n = 1; cs_n = 1; pol = 0; sar = 16'hc35a;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    arst_n = 1;
    repeat (4) @(negedge clk);
    check(32'(dlo), 32'h0);
    check(32'(rng), 32'h0);
    // parallel conversion, result split over low bus and shared pins
    run_conv(hi, shc);
    check(32'(hi), 32'(CONV_CYC));
    check(32'(shc), 32'(CONV_CYC));
    check(32'({o15, o14, dlo}), 32'(sar));
    // output drivers for every read/select combination
    for (s = 0; s < 2; s++) begin
      for (k = 0; k < 4; k++) begin
        ser = s[0];
        {rd_n, cs_n} = k[1:0];
        repeat (4) @(negedge clk);
        check(32'(doe), 32'(k != 0 || s != 0));
        check(32'(soe), 32'(k == 0 && s != 0));
        if (s == 0) check(32'({oe15, oe14}), 32'(k != 0 ? 2'h3 : 2'h0));
        else check(32'({oe15, oe14}), 32'h3);
      end
    end
    {rd_n, cs_n} = 2'h3;
    // pin configuration: every range code, config port ignored
    for (k = 0; k < 4; k++) begin
      {bip, wide_range_select} = k[1:0];
      repeat (4) @(negedge clk);
      check(32'(rng), 32'(k));
    end
    host.shift_byte(8'ha5, 1'b0, 1'b1);
    check(32'(cfg), 32'h0);
    // register configuration on rising, then falling shift edges
    hw = 0;
    host.shift_byte(8'ha5, 1'b0, 1'b1);
    check(32'(cfg), 32'ha5);
    check(32'(rng), 32'h1);
    pol = 1;
    host.shift_byte(8'h3c, 1'b1, 1'b1);
    check(32'(cfg), 32'h3c);
    host.shift_byte(8'hff, 1'b1, 1'b0);
    check(32'(cfg), 32'h3c);
    // external serial clock gated by chip select
    ext = 1;
    for (k = 0; k < 2; k++) begin
      cs_n = k[0];
      repeat (4) @(negedge clk);
      check(32'(gate), 32'(k == 0));
    end
    // master read-after-convert lengthens busy only
    cs_n = 1;
    ext = 0;
    read_during_convert_sel = 0;
    sar = 16'h1234;
    run_conv(hi, shc);
    check(32'(hi), 32'(CONV_CYC) + 32'(EXT_CYC));
    check(32'(shc), 32'(CONV_CYC));
    check(32'({o15, o14, dlo}), 32'h1234);
    // power down mid-conversion: it finishes, the next start is refused
    ser = 0;
    read_during_convert_sel = 1;
    sar = 16'h0ff0;
    host.start_conv();
    pd = 1;
    host.wait_ready(ok);
    check(32'(ok), 32'h1);
    check(32'({o15, o14, dlo}), 32'h0ff0);
    host.start_conv();
    repeat (10) @(negedge clk);
    check(32'(busy), 32'h0);
    check(32'(pdo), 32'h1);
    pd = 0;
    // reset pin mid-conversion: aborted, outputs and config cleared
    repeat (4) @(negedge clk);
    host.start_conv();
    repeat (20) @(negedge clk);
    rst_pin = 1;
    repeat (4) @(negedge clk);
    check(32'(busy), 32'h0);
    rst_pin = 0;
    repeat (4) @(negedge clk);
    check(32'({o15, o14, dlo}), 32'h0);
    check(32'(cfg), 32'h0);
    repeat (500) @(negedge clk);
    check(32'({o15, o14, dlo}), 32'h0);
    end_of_test();
  end
endmodule : adcc_ctrl_bench

// File: adcc_host.sv
// host model: drives conversion start and the serial configuration port
`timescale 1ns/100ps
module adcc_host (
  input  wire logic i_sys_clk,         // system clock, host steps on falling edge
  input  wire logic i_busy,            // converter busy
  output logic      o_convert_start_n, // conversion start, low active
  output logic      o_sck,             // configuration shift clock
  output logic      o_sel_n,           // configuration port select, low active
  output logic      o_sdata            // configuration data
);
  // ************************************************************
  // idle levels and host actions
  // ************************************************************
  initial begin
    o_convert_start_n = 1'b1;
    o_sck             = 1'b0;
    o_sel_n           = 1'b1;
    o_sdata           = 1'b0;
  end

  // start edge held low long enough to pass the pin synchroniser
  task automatic start_conv();
    @(negedge i_sys_clk) o_convert_start_n <= 1'b0;
    repeat (4) @(negedge i_sys_clk);
    o_convert_start_n <= 1'b1;
  endtask : start_conv

  // the result is only taken once busy has dropped, bounded wait
  task automatic wait_ready(output logic ok);
    int k;
    ok = 1'b0;
    for (k = 0; k < 1000 && !ok; k++) begin
      @(negedge i_sys_clk);
      ok = (i_busy === 1'b0);
    end
  endtask : wait_ready

  // one byte, msb first; clock idles at its inactive level between frames
  // data flips before the inactive edge, so a wrong-edge sampler sees garbage
  task automatic shift_byte(input logic [7:0] v, input logic pol, input logic sel);
    int i;
    @(negedge i_sys_clk) o_sck <= pol;
    repeat (4) @(negedge i_sys_clk);
    o_sel_n <= ~sel;
    for (i = 7; i >= 0; i--) begin
      o_sdata <= v[i];
      repeat (4) @(negedge i_sys_clk);
      o_sck <= ~pol;
      repeat (2) @(negedge i_sys_clk);
      o_sdata <= ~v[i];
      repeat (2) @(negedge i_sys_clk);
      o_sck <= pol;
    end
    repeat (4) @(negedge i_sys_clk);
    o_sel_n <= 1'b1;
    o_sdata <= ~o_sdata;
  endtask : shift_byte
endmodule : adcc_host

// File: adcc_pkg.sv
// constants, indices and types shared by the converter control block
// Notes on behaviour
// - parallel mode drives bits 14, 15 on shared pins
// - software serial mode shifts configuration bits in
// - polarity pin picks the configuration sampling edge
// - configuration select must be asserted to shift
// - busy high from start until result loaded
// - master read-after-convert mode lengthens busy time
// - range from signed and wide pins, or from the register in register configuration; both low unipolar
// - data drivers on only with read and select low
// - chip select gates external serial data clock
// - reset high aborts conversion without any result
// - reset falling edge zeroes data, clears configuration
// - falling convert start holds sampler and converts
// - power-down finishes current conversion, refuses new ones
package adcc_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;   // 100 MHz system clock
  localparam int CONV_TIME_NS  = 4000; // conversion length, least
  localparam int EXT_TIME_NS   = 1000; // extra busy in read-after-convert master mode
  localparam logic [15:0] CONV_CYC =
    16'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] EXT_CYC =
    16'((EXT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ************************************************************
  // data and configuration layout
  // ************************************************************
  localparam int          RES_W       = 16;    // result width
  localparam int          CFG_W       = 8;     // configuration register width
  localparam logic [7:0]  CFG_RESET   = 8'h00; // configuration default
  localparam int          CFG_TEN_BIT = 0;     // wide range field
  localparam int          CFG_BIP_BIT = 1;     // signed range field
  localparam int          BIT14       = 14;    // result bit on shared pin a
  localparam int          BIT15       = 15;    // result bit on shared pin b

  // ************************************************************
  // positions in the synchronised pin vector
  // ************************************************************
  localparam int SYNC_W = 15;
  localparam int S_CNV  = 0;  // convert start, low active
  localparam int S_PD   = 1;  // power down
  localparam int S_RST  = 2;  // reset pin, high active
  localparam int S_SER  = 3;  // serial (1) / parallel (0)
  localparam int S_HW   = 4;  // pin (1) / register (0) configuration
  localparam int S_EXT  = 5;  // external (1) / internal (0) serial clock
  localparam int S_RDC  = 6;  // read during convert
  localparam int S_TEN  = 7;  // wide range
  localparam int S_BIP  = 8;  // signed range
  localparam int S_RD   = 9;  // read strobe, low active
  localparam int S_CS   = 10; // chip select, low active
  localparam int S_POL  = 11; // configuration clock polarity
  localparam int S_SCK  = 12; // shared pin a as shift clock
  localparam int S_SEL  = 13; // shared pin b as port select, low active
  localparam int S_SIN  = 14; // configuration serial data

  // reset level of each synchronised pin: low-active pins start inactive,
  // so reset release reads as no start edge and no enabled driver
  localparam logic [SYNC_W-1:0] SYNC_IDLE =
    SYNC_W'((1 << S_CNV) | (1 << S_RD) | (1 << S_CS) | (1 << S_SEL));

  // conversion sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_EXTEND} adcc_state_t;

endpackage : adcc_pkg

// File: adcc_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module adcc_sync
  import adcc_pkg::*;
#(
  parameter int           W       = SYNC_W, // number of pins
  parameter logic [W-1:0] RST_VAL = '0      // level both stages hold in reset
) (
  input  wire logic         i_sys_clk, // system clock
  input  wire logic         i_arst_n,  // async reset, low active
  input  wire logic [W-1:0] i_async,   // raw pins
  output logic      [W-1:0] o_sync     // synchronised pins
);

  logic [W-1:0] meta; // first stage, read only by the second

  // ************************************************************
  // two flops per bit; no logic looks at the first stage
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : adcc_sync
